// ---- rtl/vbf_pkg.sv ----
package vbf_pkg;

	// Host register map (byte subaddresses).
	localparam logic [7:0] ADDR_WORD_COUNT = 8'hBC;
	localparam logic [7:0] ADDR_THRESHOLD = 8'hBD;
	localparam logic [7:0] ADDR_FLUSH = 8'hBF;
	localparam logic [7:0] ADDR_ROUTE = 8'hC0;
	localparam logic [7:0] ADDR_LINE_EVENT = 8'hC1;
	localparam logic [7:0] ADDR_SWITCH_LO = 8'hC2;
	localparam logic [7:0] ADDR_SWITCH_HI = 8'hC3;
	localparam logic [7:0] ADDR_FIRST_LINE = 8'hD6;
	localparam logic [7:0] ADDR_LAST_LINE = 8'hD7;
	localparam logic [7:0] ADDR_REGION_STD = 8'hD8;
	localparam logic [7:0] ADDR_WHOLE_EN = 8'hD9;
	localparam logic [7:0] ADDR_WHOLE_STD = 8'hDA;
	localparam logic [7:0] ADDR_SCAN_TYPE = 8'hDB;
	localparam logic [7:0] ADDR_IND_FIXED = 8'hE0;
	localparam logic [7:0] ADDR_IND_AUTOINC = 8'hE1;
	localparam logic [7:0] ADDR_FIFO_READ = 8'hE2;
	localparam logic [7:0] ADDR_IND_LOW = 8'hE8;
	localparam logic [7:0] ADDR_IND_MID = 8'hE9;
	localparam logic [7:0] ADDR_IND_HIGH = 8'hEA;
	localparam logic [7:0] ADDR_RAW_A = 8'hF0;
	localparam logic [7:0] ADDR_RAW_B = 8'hF1;
	localparam logic [7:0] ADDR_MASKED_A = 8'hF2;
	localparam logic [7:0] ADDR_MASKED_B = 8'hF3;
	localparam logic [7:0] ADDR_MASK_A = 8'hF4;
	localparam logic [7:0] ADDR_MASK_B = 8'hF5;
	localparam logic [7:0] ADDR_CLEAR_A = 8'hF6;
	localparam logic [7:0] ADDR_CLEAR_B = 8'hF7;

	// Reset values.
	localparam logic [7:0] RST_THRESHOLD = 8'h80;
	localparam logic [9:0] RST_SWITCH_POS = 10'h01E;
	localparam logic [7:0] RST_FIRST_LINE = 8'h06;
	localparam logic [7:0] RST_LAST_LINE = 8'h1B;
	localparam logic [7:0] RST_STANDARD = 8'hFF;
	localparam logic [7:0] NO_SLICE = 8'hFF;

	// Field positions.
	localparam int ROUTE_HOST_BIT = 0;
	localparam int ROUTE_OTHER_BIT = 1;
	localparam int LINE_F1_BIT = 7;
	localparam int LINE_F2_BIT = 6;
	localparam int WHOLE_EN_BIT = 0;
	localparam int FLAG_THRESHOLD = 7;
	localparam int FLAG_LINE = 0;
	localparam int FLAG_FULL = 0;

	// FIFO geometry, in bytes; a word is two bytes.
	localparam int FIFO_AW = 9;
	localparam int FIFO_CW = 10;
	localparam logic [9:0] FIFO_DEPTH = 10'h200;
	localparam logic [8:0] WORD_LIMIT = 9'h0FF;
	localparam logic [5:0] LINE_MIN = 6'h02;

endpackage

// ---- rtl/vbf_regs.sv ----
`timescale 1ns/100ps

// How it works
// - Count register shows stored FIFO words.
// - Threshold flag when words exceed threshold.
// - Flush write empties FIFO, clears data registers.
// - Route bit picks video output or host.
// - Line event above value, per-field enables.
// - Line values zero and one never fire.
// - Standard switches at programmed pixel position.
// - Global mode only between first and last.
// - Line beats global, global beats whole field, except in active video when whole field is on.
// - Whole field slices active lines and FFh lines.
// - Scan type bit: interlaced zero, progressive one.
// - Fixed data port keeps indirect address.
// - Incrementing data port advances address per byte.
// - Teletext always via FIFO, others selectable.
// - Raw flag bit layout, threshold to line.
// - Full flag when a line cannot enter.
// - Unfitting line dropped whole, later short fits.
// - Masked flag is raw AND mask.
// - Interrupt output ORs all masked flags.
// - Reads leave flags; flags stay until cleared.
// - Writing one clears flag, zero ignored.
// - Interrupt drops when no masked flag remains.
module vbf_regs (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic vclk,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic sl_line_start,
	input wire logic [9:0] sl_line_len,
	input wire logic sl_line_teletext,
	input wire logic sl_byte_valid,
	input wire logic [7:0] sl_byte,
	input wire logic [5:0] sl_avail,
	output logic sl_data_clear,
	output logic [23:0] ib_addr,
	output logic ib_wr,
	output logic ib_rd,
	output logic [7:0] ib_wdata,
	input wire logic [7:0] ib_rdata,
	input wire logic scan_progressive_pin,
	input wire logic vid_hsync,
	input wire logic [9:0] vid_line,
	input wire logic vid_field2,
	input wire logic vid_vblank,
	input wire logic [7:0] vid_line_mode,
	output logic [7:0] slice_standard,
	output logic standard_switch,
	output logic [7:0] y_out,
	output logic y_valid,
	output logic host_irq
);

	logic [7:0] threshold;
	logic [1:0] route;
	logic [7:0] line_setup;
	logic [9:0] switch_pos;
	logic [7:0] first_line;
	logic [7:0] last_line;
	logic [7:0] region_std;
	logic whole_en;
	logic [7:0] whole_std;
	logic [7:0] mask_a;
	logic mask_b;
	logic [7:0] raw_a;
	logic raw_b;
	logic [7:0] mem [0:511];
	logic [8:0] wptr;
	logic [8:0] rptr;
	logic [9:0] count;
	logic [9:0] next_count;
	logic line_open;
	logic ind_inc;
	logic scan_s1, scan_s2, scan_s3, scan_type;
	logic ev_s1, ev_s2, ev_s3;
	logic rq_s1, rq_s2, rq_s3;
	logic ack_tgl;
	logic ev_tgl, rq_tgl;
	logic [7:0] y_data;
	logic y_got;
	logic [7:0] word_count;
	logic flush, fits, wanted, push, host_pop, y_pop, pop, ind_hit;
	logic [7:0] set_a;
	logic [7:0] clr_a;

	assign flush = reg_wr && reg_addr == vbf_pkg::ADDR_FLUSH;
	assign ind_hit = reg_addr == vbf_pkg::ADDR_IND_FIXED || reg_addr == vbf_pkg::ADDR_IND_AUTOINC;

	// Host-written configuration; every field returns to its default on reset.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			threshold <= vbf_pkg::RST_THRESHOLD;
			route <= 2'h0;
			line_setup <= 8'h00;
			switch_pos <= vbf_pkg::RST_SWITCH_POS;
			first_line <= vbf_pkg::RST_FIRST_LINE;
			last_line <= vbf_pkg::RST_LAST_LINE;
			region_std <= vbf_pkg::RST_STANDARD;
			whole_en <= 1'b0;
			whole_std <= vbf_pkg::RST_STANDARD;
			mask_a <= 8'h00;
			mask_b <= 1'b0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				vbf_pkg::ADDR_THRESHOLD: threshold <= reg_wdata;
				vbf_pkg::ADDR_ROUTE: route <= reg_wdata[1:0];
				vbf_pkg::ADDR_LINE_EVENT: line_setup <= reg_wdata;
				vbf_pkg::ADDR_SWITCH_LO: switch_pos[7:0] <= reg_wdata;
				vbf_pkg::ADDR_SWITCH_HI: switch_pos[9:8] <= reg_wdata[1:0];
				vbf_pkg::ADDR_FIRST_LINE: first_line <= reg_wdata;
				vbf_pkg::ADDR_LAST_LINE: last_line <= reg_wdata;
				vbf_pkg::ADDR_REGION_STD: region_std <= reg_wdata;
				vbf_pkg::ADDR_WHOLE_EN: whole_en <= reg_wdata[vbf_pkg::WHOLE_EN_BIT];
				vbf_pkg::ADDR_WHOLE_STD: whole_std <= reg_wdata;
				vbf_pkg::ADDR_MASK_A: mask_a <= reg_wdata;
				vbf_pkg::ADDR_MASK_B: mask_b <= reg_wdata[vbf_pkg::FLAG_FULL];
				default: ;
			endcase
		end
	end

	// FIFO admission: a line enters whole or not at all, so the reader never sees a torn line.
	assign wanted = sl_line_teletext || route[vbf_pkg::ROUTE_OTHER_BIT];
	assign fits = sl_line_len <= (vbf_pkg::FIFO_DEPTH - count);
	assign push = sl_byte_valid && line_open && count != vbf_pkg::FIFO_DEPTH && !flush;
	assign host_pop = reg_rd && reg_addr == vbf_pkg::ADDR_FIFO_READ && route[vbf_pkg::ROUTE_HOST_BIT]
		&& count != 10'h000;
	assign y_pop = (rq_s2 ^ rq_s3) && !route[vbf_pkg::ROUTE_HOST_BIT] && count != 10'h000;
	assign pop = host_pop || y_pop;
	assign next_count = count + {9'h000, push} - {9'h000, pop};
	assign word_count = (count[9:1] > vbf_pkg::WORD_LIMIT) ? 8'hFF : count[8:1];

	// Line gate; a flush also abandons a line in progress.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			line_open <= 1'b0;
		else if (flush)
			line_open <= 1'b0;
		else if (sl_line_start)
			line_open <= wanted && fits;
	end

	// Pointers and fill level.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wptr <= 9'h000;
			rptr <= 9'h000;
			count <= 10'h000;
		end
		else if (flush)
		begin
			wptr <= 9'h000;
			rptr <= 9'h000;
			count <= 10'h000;
		end
		else
		begin
			wptr <= wptr + {8'h00, push};
			rptr <= rptr + {8'h00, pop};
			count <= next_count;
		end
	end

	// Storage has no reset; the pointers define what is valid.
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wptr] <= sl_byte;
	end

	// Slicer data registers are cleared one cycle after a flush write.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sl_data_clear <= 1'b0;
		else
			sl_data_clear <= flush;
	end

	// Event flags; a set arriving with its clear wins, so no event is lost.
	assign set_a = {word_count > threshold, sl_avail, ev_s2 ^ ev_s3};
	assign clr_a = (reg_wr && reg_addr == vbf_pkg::ADDR_CLEAR_A) ? reg_wdata : 8'h00;
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			raw_a <= 8'h00;
			raw_b <= 1'b0;
		end
		else
		begin
			raw_a <= (raw_a & ~clr_a) | set_a;
			raw_b <= (raw_b && !(reg_wr && reg_addr == vbf_pkg::ADDR_CLEAR_B
				&& reg_wdata[vbf_pkg::FLAG_FULL])) || (sl_line_start && wanted && !fits);
		end
	end

	// Interrupt level follows the masked flags with no extra delay.
	assign host_irq = |(raw_a & mask_a) || (raw_b && mask_b);

	// Scan type pin: counted only when the second and third stages agree.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scan_s1 <= 1'b0;
			scan_s2 <= 1'b0;
			scan_s3 <= 1'b0;
			scan_type <= 1'b0;
		end
		else
		begin
			scan_s1 <= scan_progressive_pin;
			scan_s2 <= scan_s1;
			scan_s3 <= scan_s2;
			if (scan_s2 == scan_s3)
				scan_type <= scan_s3;
		end
	end

	// Indirect strobes trail the host access by a cycle; the address steps on the edge that ends the strobe.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ib_wr <= 1'b0;
			ib_rd <= 1'b0;
			ib_wdata <= 8'h00;
			ind_inc <= 1'b0;
		end
		else
		begin
			ib_wr <= reg_wr && ind_hit;
			ib_rd <= reg_rd && ind_hit;
			ind_inc <= (reg_wr || reg_rd) && reg_addr == vbf_pkg::ADDR_IND_AUTOINC;
			if (reg_wr && ind_hit)
				ib_wdata <= reg_wdata;
		end
	end

	// Indirect address: host byte writes, else a step after each incrementing access.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			ib_addr <= 24'h00_0000;
		else if (reg_wr && reg_addr == vbf_pkg::ADDR_IND_LOW)
			ib_addr[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == vbf_pkg::ADDR_IND_MID)
			ib_addr[15:8] <= reg_wdata;
		else if (reg_wr && reg_addr == vbf_pkg::ADDR_IND_HIGH)
			ib_addr[23:16] <= reg_wdata;
		else if ((ib_wr || ib_rd) && ind_inc)
			ib_addr <= ib_addr + 24'h00_0001;
	end

	// Read answers; indirect reads land one cycle later than the rest.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= (reg_rd && !ind_hit) || ib_rd;
			if (ib_rd)
				reg_rdata <= ib_rdata;
			else if (reg_rd)
			begin
				case (reg_addr)
					vbf_pkg::ADDR_WORD_COUNT: reg_rdata <= word_count;
					vbf_pkg::ADDR_THRESHOLD: reg_rdata <= threshold;
					vbf_pkg::ADDR_ROUTE: reg_rdata <= {6'h00, route};
					vbf_pkg::ADDR_LINE_EVENT: reg_rdata <= line_setup;
					vbf_pkg::ADDR_SWITCH_LO: reg_rdata <= switch_pos[7:0];
					vbf_pkg::ADDR_SWITCH_HI: reg_rdata <= {6'h00, switch_pos[9:8]};
					vbf_pkg::ADDR_FIRST_LINE: reg_rdata <= first_line;
					vbf_pkg::ADDR_LAST_LINE: reg_rdata <= last_line;
					vbf_pkg::ADDR_REGION_STD: reg_rdata <= region_std;
					vbf_pkg::ADDR_WHOLE_EN: reg_rdata <= {7'h00, whole_en};
					vbf_pkg::ADDR_WHOLE_STD: reg_rdata <= whole_std;
					vbf_pkg::ADDR_SCAN_TYPE: reg_rdata <= {7'h00, scan_type};
					vbf_pkg::ADDR_FIFO_READ: reg_rdata <= host_pop ? mem[rptr] : 8'h00;
					vbf_pkg::ADDR_IND_LOW: reg_rdata <= ib_addr[7:0];
					vbf_pkg::ADDR_IND_MID: reg_rdata <= ib_addr[15:8];
					vbf_pkg::ADDR_IND_HIGH: reg_rdata <= ib_addr[23:16];
					vbf_pkg::ADDR_RAW_A: reg_rdata <= raw_a;
					vbf_pkg::ADDR_RAW_B: reg_rdata <= {7'h00, raw_b};
					vbf_pkg::ADDR_MASKED_A: reg_rdata <= raw_a & mask_a;
					vbf_pkg::ADDR_MASKED_B: reg_rdata <= {7'h00, raw_b && mask_b};
					vbf_pkg::ADDR_MASK_A: reg_rdata <= mask_a;
					vbf_pkg::ADDR_MASK_B: reg_rdata <= {7'h00, mask_b};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Video-side handshakes arrive as toggles; each request is answered with one ack toggle.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ev_s1 <= 1'b0;
			ev_s2 <= 1'b0;
			ev_s3 <= 1'b0;
			rq_s1 <= 1'b0;
			rq_s2 <= 1'b0;
			rq_s3 <= 1'b0;
			ack_tgl <= 1'b0;
			y_data <= 8'h00;
			y_got <= 1'b0;
		end
		else
		begin
			ev_s1 <= ev_tgl;
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
			rq_s1 <= rq_tgl;
			rq_s2 <= rq_s1;
			rq_s3 <= rq_s2;
			if (rq_s2 ^ rq_s3)
			begin
				ack_tgl <= ~ack_tgl;
				y_got <= y_pop;
				y_data <= y_pop ? mem[rptr] : 8'h00;
			end
		end
	end

	// ---- Video clock domain ----
	// Configuration is quasi-static; a change mid-line may be seen one line late.
	// Each copy passes three flops and lands only when two samples agree, so no torn word is used.
	localparam logic [51:0] CFG_RST = {1'b0, 8'h00, vbf_pkg::RST_SWITCH_POS,
		vbf_pkg::RST_FIRST_LINE, vbf_pkg::RST_LAST_LINE, vbf_pkg::RST_STANDARD, 1'b0,
		vbf_pkg::RST_STANDARD};
	logic [51:0] cfg_bus, cfg_v1, cfg_v2, cfg_v3, cfg_live;
	logic v_route_host;
	logic [7:0] v_line_setup, v_first, v_last, v_region, v_whole_std;
	logic [9:0] v_switch;
	logic v_whole_en;
	logic hs_d, hs_fall, line_hit, pending;
	logic ak_s1, ak_s2, ak_s3;
	logic [9:0] pix;
	logic [9:0] line_prev;
	logic [7:0] next_standard;

	assign cfg_bus = {route[vbf_pkg::ROUTE_HOST_BIT], line_setup, switch_pos, first_line, last_line,
		region_std, whole_en, whole_std};
	assign {v_route_host, v_line_setup, v_switch, v_first, v_last, v_region, v_whole_en,
		v_whole_std} = cfg_live;
	assign hs_fall = hs_d && !vid_hsync;
	assign line_hit = v_line_setup[5:0] >= vbf_pkg::LINE_MIN
		&& vid_line > {4'h0, v_line_setup[5:0]} && line_prev <= {4'h0, v_line_setup[5:0]}
		&& (vid_field2 ? v_line_setup[vbf_pkg::LINE_F2_BIT]
		: v_line_setup[vbf_pkg::LINE_F1_BIT]);

	// Slicing choice: per-line code, then region code, then whole field.
	// Active video under whole-field mode always takes the whole-field standard.
	always_comb
	begin
		if (v_whole_en && !vid_vblank)
			next_standard = v_whole_std;
		else if (vid_line_mode != vbf_pkg::NO_SLICE)
			next_standard = vid_line_mode;
		else if (vid_line >= {2'h0, v_first} && vid_line <= {2'h0, v_last}
			&& v_region != vbf_pkg::NO_SLICE)
			next_standard = v_region;
		else if (v_whole_en)
			next_standard = v_whole_std;
		else
			next_standard = vbf_pkg::NO_SLICE;
	end

	// Pixel counter from the falling sync edge, and the standard switch point.
	always_ff @(posedge vclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_v1 <= CFG_RST;
			cfg_v2 <= CFG_RST;
			cfg_v3 <= CFG_RST;
			cfg_live <= CFG_RST;
			hs_d <= 1'b1;
			pix <= 10'h3FF; // Parked at 3FFh until the first sync edge; only a switch position of 3FFh pulses before it.
			line_prev <= 10'h000;
			ev_tgl <= 1'b0;
			standard_switch <= 1'b0;
			slice_standard <= vbf_pkg::NO_SLICE;
		end
		else
		begin
			cfg_v1 <= cfg_bus;
			cfg_v2 <= cfg_v1;
			cfg_v3 <= cfg_v2;
			if (cfg_v2 == cfg_v3)
				cfg_live <= cfg_v3;
			hs_d <= vid_hsync;
			pix <= hs_fall ? 10'h000 : (pix == 10'h3FF ? pix : pix + 10'h001);
			line_prev <= vid_line;
			if (line_hit)
				ev_tgl <= ~ev_tgl;
			standard_switch <= !hs_fall && pix == v_switch;
			if (!hs_fall && pix == v_switch)
				slice_standard <= next_standard;
		end
	end

	// Video output drain: one byte request in flight at a time.
	always_ff @(posedge vclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rq_tgl <= 1'b0;
			pending <= 1'b0;
			ak_s1 <= 1'b0;
			ak_s2 <= 1'b0;
			ak_s3 <= 1'b0;
			y_out <= 8'h00;
			y_valid <= 1'b0;
		end
		else
		begin
			ak_s1 <= ack_tgl;
			ak_s2 <= ak_s1;
			ak_s3 <= ak_s2;
			y_valid <= 1'b0;
			if (ak_s2 ^ ak_s3)
			begin
				pending <= 1'b0;
				y_valid <= y_got;
				if (y_got)
					y_out <= y_data;
			end
			else if (!pending && !v_route_host)
			begin
				rq_tgl <= ~rq_tgl;
				pending <= 1'b1;
			end
		end
	end

	// ---- Checks ----
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence inc_access;
		reg_wr && reg_addr == vbf_pkg::ADDR_IND_AUTOINC;
	endsequence
	sequence fixed_access;
		reg_wr && reg_addr == vbf_pkg::ADDR_IND_FIXED;
	endsequence

	threshold_flag_a: assert property (
		word_count > threshold |=> raw_a[vbf_pkg::FLAG_THRESHOLD])
		else $error("threshold flag not set");
	flush_empty_a: assert property (flush |=> count == 10'h000 && sl_data_clear)
		else $error("flush did not empty FIFO");
	flag_hold_a: assert property (raw_a[6] && !clr_a[6] |=> raw_a[6])
		else $error("flag dropped without clear");
	flag_clear_a: assert property (clr_a[7] && !set_a[7] |=> !raw_a[7])
		else $error("clear did not clear flag");
	irq_follow_a: assert property (
		(raw_a & mask_a) == 8'h00 && !(raw_b && mask_b) |-> !host_irq)
		else $error("irq high with no masked flag");
	full_drop_a: assert property (
		sl_line_start && wanted && !fits |=> !line_open && raw_b)
		else $error("oversize line admitted");
	pop_count_a: assert property (host_pop && !push |=> count == $past(count) - 10'h001)
		else $error("host read did not pop");
	autoinc_step_a: assert property (
		inc_access |=> ib_wr ##1 ib_addr == $past(ib_addr, 2) + 24'h00_0001)
		else $error("address did not step");
	fixed_keep_a: assert property (
		fixed_access |=> ib_wr ##1 ib_addr == $past(ib_addr, 2))
		else $error("fixed port moved address");
	line_invalid_a: assert property (@(posedge vclk) disable iff (!rst_b)
		v_line_setup[5:0] < vbf_pkg::LINE_MIN |-> !line_hit)
		else $error("line event on invalid value");
	switch_point_a: assert property (@(posedge vclk) disable iff (!rst_b)
		standard_switch |-> $past(pix) == $past(v_switch))
		else $error("switch at wrong pixel");

endmodule

// ---- sim/vbf_ibus_model.sv ----
`timescale 1ns/100ps

// Behavioural register store on the far side of the internal indirect bus.
module vbf_ibus_model (
	input wire logic mclk,
	input wire logic [23:0] ib_addr,
	input wire logic ib_wr,
	input wire logic ib_rd,
	input wire logic [7:0] ib_wdata,
	output logic [7:0] ib_rdata
);
	logic [7:0] mem [256];

	// Writes land on the strobe edge; only the low address byte picks a cell.
	always @(posedge mclk)
	begin
		if (ib_wr)
			mem[ib_addr[7:0]] <= ib_wdata;
	end

	// Outside a read strobe the lines show the inverse, so stale data never passes.
	assign ib_rdata = ib_rd ? mem[ib_addr[7:0]] : ~mem[ib_addr[7:0]];
endmodule

// ---- sim/vbi_fifo_host_interrupt_regs_tb.sv ----
`timescale 1ns/100ps

module vbi_fifo_host_interrupt_regs_tb;
	logic mclk = 1'b0;
	logic vclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic sl_line_start = 1'b0;
	logic [9:0] sl_line_len = 10'h000;
	logic sl_line_teletext = 1'b0;
	logic sl_byte_valid = 1'b0;
	logic [7:0] sl_byte = 8'h00;
	logic [5:0] sl_avail = 6'h00;
	logic sl_data_clear;
	logic [23:0] ib_addr;
	logic ib_wr;
	logic ib_rd;
	logic [7:0] ib_wdata;
	logic [7:0] ib_rdata;
	logic scan_progressive_pin = 1'b0;
	logic vid_hsync = 1'b1;
	logic [9:0] vid_line = 10'h000;
	logic vid_field2 = 1'b0;
	logic vid_vblank = 1'b0;
	logic [7:0] vid_line_mode = 8'hFF;
	logic [7:0] slice_standard;
	logic standard_switch;
	logic [7:0] y_out;
	logic y_valid;
	logic host_irq;
	int num_errors = 0;
	int num_checks = 0;
	int clr_seen = 0;

	// The link clock is unrelated in phase to the register clock.
	always #5 mclk = ~mclk;
	always #24 vclk = ~vclk;

	vbf_regs uut (
		.mclk(mclk), .rst_b(rst_b), .vclk(vclk),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sl_line_start(sl_line_start), .sl_line_len(sl_line_len),
		.sl_line_teletext(sl_line_teletext), .sl_byte_valid(sl_byte_valid),
		.sl_byte(sl_byte), .sl_avail(sl_avail), .sl_data_clear(sl_data_clear),
		.ib_addr(ib_addr), .ib_wr(ib_wr), .ib_rd(ib_rd), .ib_wdata(ib_wdata),
		.ib_rdata(ib_rdata), .scan_progressive_pin(scan_progressive_pin),
		.vid_hsync(vid_hsync), .vid_line(vid_line), .vid_field2(vid_field2),
		.vid_vblank(vid_vblank), .vid_line_mode(vid_line_mode), .slice_standard(slice_standard),
		.standard_switch(standard_switch), .y_out(y_out), .y_valid(y_valid),
		.host_irq(host_irq)
	);

	vbf_ibus_model ibus (
		.mclk(mclk), .ib_addr(ib_addr), .ib_wr(ib_wr), .ib_rd(ib_rd),
		.ib_wdata(ib_wdata), .ib_rdata(ib_rdata)
	);

	// Counts data-clear pulses handed to the slicer side.
	always @(posedge mclk)
	begin
		if (sl_data_clear === 1'b1)
			clr_seen++;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A wait that runs out of its bound ends the run as a mismatch.
	task automatic expire(input string nm);
		num_errors++;
		$display("[FAIL] %s expected done seen timeout", nm);
		final_report();
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Register write; a spare cycle keeps the strobe from being raised twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask

	// Register read; the answer is taken in the cycle that marks it valid.
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		int n;
		n = 0;
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		while (reg_rvalid !== 1'b1 && n < 8)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 8)
			expire(nm);
		chk(nm, reg_rdata, e);
		@(negedge mclk);
	endtask

	// One sliced line: announcement, then the given number of bytes.
	task automatic line(input logic [9:0] len, input int nb, input logic tt, input logic [7:0] b0);
		sl_line_start = 1'b1;
		sl_line_len = len;
		sl_line_teletext = tt;
		@(negedge mclk);
		sl_line_start = 1'b0;
		for (int i = 0; i < nb; i++)
		begin
			sl_byte_valid = 1'b1;
			sl_byte = b0 + 8'(i);
			@(negedge mclk);
		end
		sl_byte_valid = 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	// Measures the switch pulse from a falling sync edge, in link clocks.
	task automatic sw(input logic [9:0] pos);
		int n;
		n = 0;
		wr(8'hC2, pos[7:0]);
		wr(8'hC3, {6'h00, pos[9:8]});
		repeat (3) @(negedge vclk);
		vid_hsync = 1'b0;
		while (standard_switch !== 1'b1 && n < 80)
		begin
			@(negedge vclk);
			n++;
		end
		vid_hsync = 1'b1;
		chk("switch_at", {7'h00, n >= int'(pos) && n <= int'(pos) + 4}, 8'h01);
		@(negedge mclk);
	endtask

	task automatic t_reset();
		logic [7:0] ad [15];
		logic [7:0] ex [15];
		ad = '{8'hBD, 8'hC2, 8'hC3, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hC0, 8'hC1,
			8'hBC, 8'hF0, 8'hF1, 8'hE8, 8'h10};
		ex = '{8'h80, 8'h1E, 8'h00, 8'h06, 8'h1B, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wr(8'hBD, 8'h12);
		wr(8'hD6, 8'h34);
		rst_b = 1'b0;
		repeat (20) @(negedge mclk);
		rst_b = 1'b1;
		@(negedge mclk);
		for (int i = 0; i < 15; i++)
			rchk("reset_value", ad[i], ex[i]);
		chk("irq_idle", {7'h00, host_irq}, 8'h00);
		wr(8'hBC, 8'h55);
		rchk("count_ro", 8'hBC, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_fifo();
		wr(8'hC0, 8'h03);
		wr(8'hBD, 8'h02);
		line(10'd6, 6, 1'b0, 8'h11);
		rchk("word_count", 8'hBC, 8'h03);
		rchk("raw_thresh", 8'hF0, 8'h80);
		chk("irq_unmasked", {7'h00, host_irq}, 8'h00);
		rchk("fifo_byte0", 8'hE2, 8'h11);
		rchk("fifo_byte1", 8'hE2, 8'h12);
		rchk("count_after", 8'hBC, 8'h02);
		rchk("flag_kept", 8'hF0, 8'h80);
		wr(8'hF4, 8'h81);
		rchk("masked_a", 8'hF2, 8'h80);
		chk("irq_on", {7'h00, host_irq}, 8'h01);
		wr(8'hF6, 8'h00);
		rchk("clear_zero", 8'hF0, 8'h80);
		wr(8'hF6, 8'h80);
		rchk("clear_one", 8'hF0, 8'h00);
		chk("irq_off", {7'h00, host_irq}, 8'h00);
		wr(8'hF4, 8'h00);
		wr(8'hBF, 8'h5A);
		rchk("flush_count", 8'hBC, 8'h00);
		rchk("empty_read", 8'hE2, 8'h00);
		chk("data_clear", 8'(clr_seen), 8'h01);
		$display("test fifo done");
	endtask

	task automatic t_avail();
		for (int i = 0; i < 6; i++)
		begin
			sl_avail = 6'(1 << i);
			@(negedge mclk);
			sl_avail = 6'h00;
			@(negedge mclk);
			rchk("avail_flag", 8'hF0, 8'(2 << i));
			wr(8'hF6, 8'(2 << i));
		end
		rchk("avail_clear", 8'hF0, 8'h00);
		$display("test avail done");
	endtask

	task automatic t_full();
		line(10'd600, 4, 1'b0, 8'h20);
		rchk("full_flag", 8'hF1, 8'h01);
		rchk("drop_count", 8'hBC, 8'h00);
		line(10'd2, 2, 1'b0, 8'h30);
		rchk("short_count", 8'hBC, 8'h01);
		rchk("short_byte", 8'hE2, 8'h30);
		rchk("full_kept", 8'hF1, 8'h01);
		wr(8'hF5, 8'h01);
		chk("irq_full", {7'h00, host_irq}, 8'h01);
		wr(8'hF7, 8'h01);
		rchk("full_clear", 8'hF1, 8'h00);
		chk("irq_gone", {7'h00, host_irq}, 8'h00);
		wr(8'hBF, 8'h00);
		$display("test full done");
	endtask

	task automatic t_route();
		logic [7:0] got [2];
		int k;
		int n;
		k = 0;
		n = 0;
		wr(8'hC0, 8'h01);
		line(10'd2, 2, 1'b0, 8'h40);
		rchk("other_dropped", 8'hBC, 8'h00);
		line(10'd2, 2, 1'b1, 8'h5A);
		rchk("ttx_kept", 8'hBC, 8'h01);
		wr(8'hC0, 8'h00);
		while (k < 2 && n < 80)
		begin
			@(negedge vclk);
			n++;
			if (y_valid === 1'b1)
			begin
				got[k] = y_out;
				k++;
			end
		end
		if (k < 2)
			expire("video_out");
		@(negedge mclk);
		chk("y_byte0", got[0], 8'h5A);
		chk("y_byte1", got[1], 8'h5B);
		$display("test route done");
	endtask

	task automatic t_ind();
		wr(8'hE8, 8'h10);
		wr(8'hE9, 8'h00);
		wr(8'hEA, 8'h80);
		wr(8'hE1, 8'hAA);
		wr(8'hE1, 8'hBB);
		repeat (2) @(negedge mclk);
		chk("addr_inc", ib_addr[7:0], 8'h12);
		chk("addr_high", ib_addr[23:16], 8'h80);
		wr(8'hE8, 8'h10);
		rchk("fixed_rd0", 8'hE0, 8'hAA);
		rchk("fixed_rd1", 8'hE0, 8'hAA);
		rchk("inc_rd0", 8'hE1, 8'hAA);
		rchk("inc_rd1", 8'hE1, 8'hBB);
		chk("addr_end", ib_addr[7:0], 8'h12);
		wr(8'hE8, 8'h11);
		wr(8'hE0, 8'hCC);
		rchk("fixed_wr", 8'hE0, 8'hCC);
		$display("test indirect done");
	endtask

	// Walks the line number past the programmed value in one field.
	task automatic ramp(input logic f2, input logic [7:0] cfg, input logic [7:0] e);
		wr(8'hC1, cfg);
		@(negedge vclk);
		vid_field2 = f2;
		vid_line = 10'h000;
		repeat (4) @(negedge vclk);
		for (int l = 1; l < 10; l++)
		begin
			vid_line = 10'(l);
			repeat (2) @(negedge vclk);
		end
		repeat (10) @(negedge mclk);
		rchk("line_event", 8'hF0, e);
		wr(8'hF6, 8'h01);
	endtask

	task automatic t_line();
		ramp(1'b0, 8'h85, 8'h01);
		ramp(1'b1, 8'h85, 8'h00);
		ramp(1'b0, 8'h45, 8'h00);
		ramp(1'b1, 8'h45, 8'h01);
		ramp(1'b0, 8'hC1, 8'h00);
		ramp(1'b1, 8'hC0, 8'h00);
		$display("test line done");
	endtask

	// Standard chosen at the switch point: line code, then region, then whole field.
	task automatic t_std();
		wr(8'hD8, 8'h33);
		wr(8'hD9, 8'h01);
		wr(8'hDA, 8'h44);
		vid_vblank = 1'b1;
		vid_line = 10'd10;
		vid_line_mode = 8'h22;
		sw(10'h01E);
		chk("std_line", slice_standard, 8'h22);
		vid_line_mode = 8'hFF;
		sw(10'h01E);
		chk("std_region", slice_standard, 8'h33);
		vid_line = 10'd30;
		sw(10'h01E);
		chk("std_whole", slice_standard, 8'h44);
		vid_vblank = 1'b0;
		vid_line = 10'd10;
		vid_line_mode = 8'h22;
		sw(10'h01E);
		chk("std_active", slice_standard, 8'h44);
		$display("test standard done");
	endtask

	task automatic t_scan();
		scan_progressive_pin = 1'b1;
		repeat (6) @(negedge mclk);
		rchk("scan_prog", 8'hDB, 8'h01);
		scan_progressive_pin = 1'b0;
		repeat (6) @(negedge mclk);
		rchk("scan_intl", 8'hDB, 8'h00);
		$display("test scan done");
	endtask

	// Main sequence: reset for 20 clocks, then every scenario in turn.
	initial
	begin
		repeat (20) @(negedge mclk);
		rst_b = 1'b1;
		@(negedge mclk);
		sw(10'h01E);
		sw(10'h008);
		sw(10'h01E);
		$display("test switch done");
		t_reset();
		t_fifo();
		t_avail();
		t_full();
		t_route();
		t_ind();
		t_line();
		t_std();
		t_scan();
		final_report();
	end
endmodule
